// [hdl/address_code_pkg.sv]
package address_code_pkg;

    localparam int ADDR_W = 33;
    localparam int WORD_W = 21;
    localparam int WIDE_W = 36;
    localparam int QUOT_SHIFT = 15;

    // Direction select.
    localparam logic DIR_ENCODE = 1'b0;
    localparam logic DIR_DECODE = 1'b1;

    // Type letters, ASCII upper case.
    localparam logic [7:0] LETTER_FIRST_STD = 8'h41;
    localparam logic [7:0] LETTER_LAST_STD = 8'h4c;
    localparam logic [7:0] LETTER_FIXED_0 = 8'h55;
    localparam logic [7:0] LETTER_FIXED_3 = 8'h58;
    localparam logic [7:0] LETTER_ANY_NS = 8'h59;
    localparam logic [7:0] LETTER_ALL_NS = 8'h5a;

    // Address ranges of the decimal field.
    localparam logic [ADDR_W-1:0] SHORT_LIMIT = 33'h0001effff;
    localparam logic [ADDR_W-1:0] LONG1_FIRST = 33'h000201001;
    localparam logic [ADDR_W-1:0] LONG1_LAST = 33'h040201000;
    localparam logic [ADDR_W-1:0] LONG2_LAST = 33'h0c0201000;
    localparam logic [ADDR_W-1:0] LONG3_LAST = 33'h100200ffe;

    // Conversion offsets.
    localparam logic [ADDR_W-1:0] SHORT_OFFSET = 33'h000008000;
    localparam logic [ADDR_W-1:0] LONG_BASE_A = 33'h0001f9001;
    localparam logic [ADDR_W-1:0] LONG_BASE_A_M1 = 33'h0001f9000;
    localparam logic [ADDR_W-1:0] LONG_BASE_B = 33'h0001f8fff;
    localparam logic [WORD_W-1:0] WORD_ALL_ONES = 21'h1fffff;
    localparam logic [WORD_W-1:0] SET13_OFFSET = 21'h1d8000;
    localparam logic [WORD_W-1:0] SET23_W1_OFFSET = 21'h1f7fff;
    localparam logic [WORD_W-1:0] SET23_W2_OFFSET = 21'h1c8000;

    // Over-the-air word ranges used when recovering an address.
    localparam logic [WORD_W-1:0] LA1_FIRST = 21'h000001;
    localparam logic [WORD_W-1:0] LA1_LAST = 21'h008000;
    localparam logic [WORD_W-1:0] SHORT_W_FIRST = 21'h008001;
    localparam logic [WORD_W-1:0] LA34_FIRST = 21'h1e0001;
    localparam logic [WORD_W-1:0] LA34_LAST = 21'h1f0000;
    localparam logic [WORD_W-1:0] LA2_FIRST = 21'h1f7fff;
    localparam logic [WORD_W-1:0] LA2_LAST = 21'h1ffffe;

    typedef enum logic [1:0] {
        class_single,
        class_any,
        class_all,
        class_none
    } unit_class_t;

endpackage

// [hdl/phase_frame_extract.sv]
`timescale 1ns/1ps
module phase_frame_extract
    import address_code_pkg::*;
(
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [1:0] subtract,
    output logic [1:0] phase,
    output logic [6:0] frame
);

    logic [ADDR_W-1:0] adjusted;

    always_comb begin
        adjusted = addr - {{(ADDR_W-2){1'b0}}, subtract};
        phase = adjusted[3:2];
        frame = adjusted[10:4];
    end

endmodule

// [hdl/pager_address_converter.sv]
`timescale 1ns/1ps
// Function
// - Address bits 3:2 give phase a to d.
// - Address bits 10:4 give frame 0-127.
// - Subtract letter position in group first.
// - A-D single, E-H any, I-L all phase.
// - U-X fixed phases; Y any; Z all; explicit frame.
// - Short address plus 32768 forms one word.
// - Lowest long range word one: remainder plus one.
// - Lowest long range word two: complemented quotient.
// - Middle long range word two: quotient plus offset.
// - Highest range word one: remainder plus offset.
// - Highest range word two: quotient plus offset.
// - Short word minus 32768 recovers address.
// - Lowest long range recovered from complemented word.
module pager_address_converter
    import address_code_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic start,
    input wire logic direction,
    input wire logic [ADDR_W-1:0] subscriber_address_code,
    input wire logic [7:0] type_letter,
    input wire logic [6:0] explicit_frame,
    input wire logic [WORD_W-1:0] word1_in,
    input wire logic [WORD_W-1:0] word2_in,
    input wire logic long_in,
    output logic done,
    output logic [WORD_W-1:0] word1_out,
    output logic [WORD_W-1:0] word2_out,
    output logic long_out,
    output logic [ADDR_W-1:0] address_out,
    output logic [1:0] phase_out,
    output logic [6:0] frame_out,
    output unit_class_t unit_class,
    output logic illegal
);

    logic done_reg, done_next;
    logic [WORD_W-1:0] word1_reg, word1_next;
    logic [WORD_W-1:0] word2_reg, word2_next;
    logic long_reg, long_next;
    logic [ADDR_W-1:0] address_reg, address_next;
    logic [1:0] phase_reg, phase_next;
    logic [6:0] frame_reg, frame_next;
    unit_class_t class_reg, class_next;
    logic illegal_reg, illegal_next;

    // Letter decode.
    logic [7:0] letter_index;
    logic letter_std;
    logic letter_fixed;
    logic letter_ok;
    logic [1:0] subtract;
    unit_class_t letter_class;
    logic [1:0] fixed_phase;

    always_comb begin
        letter_index = type_letter - LETTER_FIRST_STD;
        letter_std = (type_letter >= LETTER_FIRST_STD) && (type_letter <= LETTER_LAST_STD);
        letter_fixed = (type_letter >= LETTER_FIXED_0) && (type_letter <= LETTER_FIXED_3);
        letter_ok = letter_std || letter_fixed || (type_letter == LETTER_ANY_NS)
            || (type_letter == LETTER_ALL_NS);
        fixed_phase = 2'(type_letter - LETTER_FIXED_0);
        subtract = letter_std ? letter_index[1:0] : 2'h0;
        if (letter_std) begin
            unique case (letter_index[3:2])
                2'h0: letter_class = class_single;
                2'h1: letter_class = class_any;
                2'h2: letter_class = class_all;
                default: letter_class = class_none;
            endcase
        end else if (letter_fixed) begin
            letter_class = class_single;
        end else if (type_letter == LETTER_ANY_NS) begin
            letter_class = class_any;
        end else if (type_letter == LETTER_ALL_NS) begin
            letter_class = class_all;
        end else begin
            letter_class = class_none;
        end
    end

    // Encoding path: decimal address to one or two words.
    logic [ADDR_W-1:0] diff_a;
    logic [ADDR_W-1:0] diff_b;
    logic [WORD_W-1:0] quot_a;
    logic [WORD_W-1:0] quot_b;
    logic [WORD_W-1:0] enc_w1;
    logic [WORD_W-1:0] enc_w2;
    logic enc_long;
    logic enc_bad;

    always_comb begin
        diff_a = subscriber_address_code - LONG_BASE_A;
        diff_b = subscriber_address_code - LONG_BASE_B;
        // Quotients stay below 2^18 inside the legal ranges.
        quot_a = WORD_W'(diff_a[ADDR_W-1:QUOT_SHIFT]);
        quot_b = WORD_W'(diff_b[ADDR_W-1:QUOT_SHIFT]);
        enc_w1 = '0;
        enc_w2 = '0;
        enc_long = 1'b0;
        enc_bad = 1'b0;
        if (subscriber_address_code < SHORT_LIMIT) begin
            enc_w1 = WORD_W'(subscriber_address_code + SHORT_OFFSET);
            enc_bad = (subscriber_address_code == '0);
        end else if (subscriber_address_code < LONG1_FIRST) begin
            enc_bad = 1'b1;
        end else if (subscriber_address_code <= LONG1_LAST) begin
            enc_long = 1'b1;
            enc_w1 = WORD_W'(diff_a[QUOT_SHIFT-1:0]) + WORD_W'(1);
            enc_w2 = WORD_ALL_ONES - quot_a;
        end else if (subscriber_address_code <= LONG2_LAST) begin
            enc_long = 1'b1;
            enc_w1 = WORD_W'(diff_a[QUOT_SHIFT-1:0]) + WORD_W'(1);
            enc_w2 = quot_a + SET13_OFFSET;
        end else if (subscriber_address_code <= LONG3_LAST) begin
            enc_long = 1'b1;
            enc_w1 = WORD_W'(diff_b[QUOT_SHIFT-1:0]) + SET23_W1_OFFSET;
            enc_w2 = quot_b + SET23_W2_OFFSET;
        end else begin
            enc_bad = 1'b1;
        end
    end

    // Decoding path: received words back to the decimal address.
    logic w1_la1;
    logic w1_la2;
    logic w2_la2;
    logic w2_la34;
    logic [WIDE_W-1:0] dec_sum;
    logic [ADDR_W-1:0] dec_addr;
    logic dec_bad;

    always_comb begin
        w1_la1 = (word1_in >= LA1_FIRST) && (word1_in <= LA1_LAST);
        w1_la2 = (word1_in >= LA2_FIRST) && (word1_in <= LA2_LAST);
        w2_la2 = (word2_in >= LA2_FIRST) && (word2_in <= LA2_LAST);
        w2_la34 = (word2_in >= LA34_FIRST) && (word2_in <= LA34_LAST);
        dec_sum = '0;
        dec_bad = 1'b0;
        if (!long_in) begin
            dec_sum = WIDE_W'(word1_in) - WIDE_W'(SHORT_OFFSET);
            dec_bad = (word1_in < SHORT_W_FIRST);
        end else if (w1_la1 && w2_la2) begin
            dec_sum = (WIDE_W'(WORD_W'(~word2_in)) << QUOT_SHIFT) + WIDE_W'(LONG_BASE_A_M1)
                + WIDE_W'(word1_in);
        end else if (w1_la1 && w2_la34) begin
            dec_sum = (WIDE_W'(word2_in - SET13_OFFSET) << QUOT_SHIFT)
                + WIDE_W'(LONG_BASE_A_M1) + WIDE_W'(word1_in);
        end else if (w1_la2 && w2_la34) begin
            dec_sum = (WIDE_W'(word2_in - SET23_W2_OFFSET) << QUOT_SHIFT)
                + WIDE_W'(word1_in - SET23_W1_OFFSET) + WIDE_W'(LONG_BASE_B);
        end else begin
            dec_bad = 1'b1;
        end
        dec_addr = dec_sum[ADDR_W-1:0];
    end

    // Phase and frame follow from whichever address this request carries.
    logic [ADDR_W-1:0] embed_addr;
    logic [1:0] std_phase;
    logic [6:0] std_frame;

    assign embed_addr = (direction == DIR_DECODE) ? dec_addr : subscriber_address_code;

    phase_frame_extract u_extract (
        .addr(embed_addr),
        .subtract(subtract),
        .phase(std_phase),
        .frame(std_frame)
    );

    always_comb begin
        done_next = start;
        word1_next = word1_reg;
        word2_next = word2_reg;
        long_next = long_reg;
        address_next = address_reg;
        phase_next = phase_reg;
        frame_next = frame_reg;
        class_next = class_reg;
        illegal_next = illegal_reg;
        if (start) begin
            class_next = letter_class;
            if (letter_std) begin
                phase_next = std_phase;
                frame_next = std_frame;
            end else begin
                phase_next = letter_fixed ? fixed_phase : 2'h0;
                frame_next = explicit_frame;
            end
            if (direction == DIR_ENCODE) begin
                word1_next = enc_w1;
                word2_next = enc_w2;
                long_next = enc_long;
                address_next = subscriber_address_code;
                illegal_next = enc_bad || !letter_ok;
            end else begin
                word1_next = word1_in;
                word2_next = word2_in;
                long_next = long_in;
                address_next = dec_addr;
                illegal_next = dec_bad || !letter_ok;
            end
        end
    end

    // Results stay until the next accepted request.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            done_reg <= 1'b0;
            word1_reg <= '0;
            word2_reg <= '0;
            long_reg <= 1'b0;
            address_reg <= '0;
            phase_reg <= 2'h0;
            frame_reg <= 7'h00;
            class_reg <= class_none;
            illegal_reg <= 1'b0;
        end else begin
            done_reg <= done_next;
            word1_reg <= word1_next;
            word2_reg <= word2_next;
            long_reg <= long_next;
            address_reg <= address_next;
            phase_reg <= phase_next;
            frame_reg <= frame_next;
            class_reg <= class_next;
            illegal_reg <= illegal_next;
        end
    end

    assign done = done_reg;
    assign word1_out = word1_reg;
    assign word2_out = word2_reg;
    assign long_out = long_reg;
    assign address_out = address_reg;
    assign phase_out = phase_reg;
    assign frame_out = frame_reg;
    assign unit_class = class_reg;
    assign illegal = illegal_reg;

endmodule

// [testbench/pager_address_converter_props.sv]
`timescale 1ns/1ps
module pager_address_converter_chk
    import address_code_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic start,
    input wire logic direction,
    input wire logic [ADDR_W-1:0] subscriber_address_code,
    input wire logic [7:0] type_letter,
    input wire logic [WORD_W-1:0] word1_in,
    input wire logic long_in,
    input wire logic done,
    input wire logic [WORD_W-1:0] word1_out,
    input wire logic [WORD_W-1:0] word2_out,
    input wire logic long_out,
    input wire logic [ADDR_W-1:0] address_out,
    input wire logic [1:0] phase_out,
    input wire logic [6:0] frame_out,
    input wire unit_class_t unit_class,
    input wire logic illegal
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // Letter A only, so that a subtracted letter position or an explicit frame never trips these.
    wire logic enc = start && direction == DIR_ENCODE && type_letter == LETTER_FIRST_STD;
    wire logic [ADDR_W-1:0] d1 = subscriber_address_code - LONG_BASE_A;
    wire logic l1 = enc && d1 < LONG1_LAST - LONG_BASE_A + 1
        && subscriber_address_code >= LONG1_FIRST;
    property p_pulse; done |-> $past(start); endproperty
    a_pulse: assert property (p_pulse) else $error("done without request");
    property p_short; enc && subscriber_address_code < SHORT_LIMIT && subscriber_address_code != 0
        |=> !long_out && word1_out == WORD_W'($past(subscriber_address_code) + SHORT_OFFSET);
    endproperty
    a_short: assert property (p_short) else $error("short word wrong");
    property p_gap; enc && subscriber_address_code >= SHORT_LIMIT
        && subscriber_address_code < LONG1_FIRST |=> illegal; endproperty
    a_gap: assert property (p_gap) else $error("gap not illegal");
    property p_l1w1; l1 |=> word1_out == WORD_W'($past(d1[14:0]) + 1); endproperty
    a_l1w1: assert property (p_l1w1) else $error("first word wrong");
    property p_l1w2; l1 |=> long_out && word2_out == ~WORD_W'($past(d1) >> QUOT_SHIFT); endproperty
    a_l1w2: assert property (p_l1w2) else $error("second word wrong");
    property p_phase; enc |=> phase_out == $past(subscriber_address_code[3:2])
        && frame_out == $past(subscriber_address_code[10:4]); endproperty
    a_phase: assert property (p_phase) else $error("phase or frame wrong");
    property p_class; start && type_letter >= LETTER_FIRST_STD && type_letter <= LETTER_LAST_STD
        |=> unit_class == 2'(($past(type_letter) - LETTER_FIRST_STD) >> 2); endproperty
    a_class: assert property (p_class) else $error("class wrong");
    property p_fixed; start && type_letter >= LETTER_FIXED_0 && type_letter <= LETTER_FIXED_3
        |=> unit_class == class_single && phase_out == 2'($past(type_letter) - LETTER_FIXED_0);
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed phase wrong");
    property p_dec; start && direction == DIR_DECODE && !long_in && word1_in >= SHORT_W_FIRST
        |=> address_out == ADDR_W'($past(word1_in)) - SHORT_OFFSET; endproperty
    a_dec: assert property (p_dec) else $error("short recovery wrong");
endmodule
bind pager_address_converter pager_address_converter_chk u_chk (.clock, .nrst, .start,
    .direction, .subscriber_address_code, .type_letter, .word1_in, .long_in, .done,
    .word1_out, .word2_out, .long_out, .address_out, .phase_out, .frame_out, .unit_class,
    .illegal);

// [testbench/tb_pager_address_converter.sv]
`timescale 1ns/1ps
module tb_pager_address_converter;
    import address_code_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic start = 1'b0;
    logic direction = 1'b0;
    logic long_in = 1'b0;
    logic [ADDR_W-1:0] subscriber_address_code = '0;
    logic [7:0] type_letter = 8'h41;
    logic [6:0] explicit_frame = 7'h55;
    logic [WORD_W-1:0] word1_in = '0;
    logic [WORD_W-1:0] word2_in = '0;
    logic done, long_out, illegal;
    logic [WORD_W-1:0] word1_out, word2_out;
    logic [ADDR_W-1:0] address_out;
    logic [1:0] phase_out;
    logic [6:0] frame_out;
    unit_class_t unit_class;
    int fail_count = 0;
    int tests_run = 0;
    always #5 clock = ~clock;
    pager_address_converter u_dut (.clock, .nrst, .start, .direction, .subscriber_address_code,
        .type_letter, .explicit_frame, .word1_in, .word2_in, .long_in, .done, .word1_out,
        .word2_out, .long_out, .address_out, .phase_out, .frame_out, .unit_class, .illegal);
    task automatic wrap_up();
        $display("Counts: %0d compared, %0d failed", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        tests_run++;
        if (seen !== want) begin
            fail_count++;
            $display("ERROR %0t: saw %0h want %0h", $time, seen, want);
        end
    endtask
    task automatic request(input logic dir, input longint a, input logic [7:0] ch,
            input logic [WORD_W-1:0] w1, input logic [WORD_W-1:0] w2, input logic lng);
        int i;
        @(posedge clock);
        start <= 1'b1;
        direction <= dir;
        subscriber_address_code <= ADDR_W'(a);
        type_letter <= ch;
        word1_in <= w1;
        word2_in <= w2;
        long_in <= lng;
        @(posedge clock);
        start <= 1'b0;
        @(negedge clock);
        for (i = 0; i < 4 && done !== 1'b1; i++) @(negedge clock);
        if (i == 4) begin
            fail_count++;
            $display("ERROR %0t: no answer", $time);
            wrap_up();
        end
    endtask
    task automatic check_letter(input longint a, input logic [7:0] ch);
        longint s;
        s = a - (ch - 8'h41) % 4;
        if (ch >= 8'h41 && ch <= 8'h4c) begin
            check(unit_class, (ch - 8'h41) / 4);
            check(phase_out, s[3:2]);
            check(frame_out, s[10:4]);
        end else if (ch >= 8'h55 && ch <= 8'h5a) begin
            check(unit_class, ch < 8'h59 ? 0 : ch - 8'h58);
            check(phase_out, ch < 8'h59 ? ch - 8'h55 : 0);
            check(frame_out, explicit_frame);
        end else begin
            check(unit_class, class_none);
        end
    endtask
    task automatic t_round(input longint a, input logic [7:0] ch);
        longint d, w1, w2;
        logic lng, bad;
        bad = a == 0 || (a >= 2031615 && a <= 2101248) || a > 64'd4297068542;
        bad = bad || !((ch >= 8'h41 && ch <= 8'h4c) || (ch >= 8'h55 && ch <= 8'h5a));
        lng = a > 2101248;
        d = a - (a > 64'd3223326720 ? 2068479 : 2068481);
        w1 = a < 2031615 ? a + 32768 : a > 64'd3223326720 ? d % 32768 + 2064383 : d % 32768 + 1;
        w2 = a > 64'd3223326720 ? d / 32768 + 1867776 : a > 1075843072 ? d / 32768 + 1933312
            : 2097151 - d / 32768;
        request(DIR_ENCODE, a, ch, '0, '0, 1'b0);
        check(illegal, bad);
        check_letter(a, ch);
        if (!bad) begin
            check(long_out, lng);
            check(word1_out, w1);
            check(word2_out, lng ? w2 : 0);
            request(DIR_DECODE, 0, ch, word1_out, word2_out, lng);
            check(address_out, a);
            check_letter(a, ch);
        end
    endtask
    task automatic t_ranges();
        longint tbl[12] = '{1, 2031614, 2031615, 2101248, 2101249, 1075843072, 1075843073,
            64'd3223326720, 64'd3223326721, 64'd4297068542, 64'd4297068543, 0};
        foreach (tbl[i]) t_round(tbl[i], 8'h41);
        $display("address ranges done");
    endtask
    task automatic t_letters();
        for (int c = 8'h41; c <= 8'h5a; c++) t_round(12345, 8'(c));
        $display("letters done");
    endtask
    task automatic t_b2b();
        @(posedge clock);
        start <= 1'b1;
        direction <= DIR_ENCODE;
        type_letter <= 8'h41;
        subscriber_address_code <= 33'h000000010;
        @(posedge clock);
        subscriber_address_code <= 33'h000000020;
        @(negedge clock);
        check(word1_out, 21'h008010);
        @(posedge clock);
        start <= 1'b0;
        @(negedge clock);
        check({done, word1_out}, {1'b1, 21'h008020});
        @(negedge clock);
        check(done, 1'b0);
        $display("back to back done");
    endtask
    task automatic t_dec_bad();
        request(DIR_DECODE, 0, 8'h41, 21'h008000, '0, 1'b0);
        check(illegal, 1'b1);
        request(DIR_DECODE, 0, 8'h41, '0, 21'h1ffffe, 1'b1);
        check({illegal, address_out}, {1'b1, 33'h000000000});
        @(posedge clock);
        nrst <= 1'b0;
        @(negedge clock);
        check({unit_class, word1_out, done}, {class_none, 21'h000000, 1'b0});
        check({long_out, illegal}, {1'b0, 1'b0});
        @(posedge clock);
        nrst <= 1'b1;
        $display("bad words and reset done");
    endtask
    initial begin
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        t_ranges();
        t_letters();
        t_b2b();
        t_dec_bad();
        t_round(1075843073, 8'h42);
        $display("second letter long round trip done");
        wrap_up();
    end
endmodule
